// file: common/mrp_defines.vh
// Shared constants for the region programming alias block
`ifndef MRP_DEFINES_VH
`define MRP_DEFINES_VH

// Register byte offsets within the block's window
`define MRP_OFS_BASE 12'h000
`define MRP_OFS_ATTR 12'h004
`define MRP_OFS_RNUM 12'h008
`define MRP_OFS_W 12

// AHB-Lite encodings
`define MRP_HSIZE_BYTE 3'h0
`define MRP_HSIZE_HALF 3'h1
`define MRP_HSIZE_WORD 3'h2
`define MRP_HTRANS_ACT 1
`define MRP_RESP_OKAY 1'b0
`define MRP_LANES_ALL 4'hF
`define MRP_LANES_LO 4'h3
`define MRP_LANES_HI 4'hC
`define MRP_LANES_ONE 4'h1
`define MRP_LANES_NONE 4'h0

// Base register fields
`define MRP_RB_VALID 4
`define MRP_RB_REG_HI 3
`define MRP_RB_REG_LO 0
`define MRP_RB_ADDR_LO 5

// Attribute register fields
`define MRP_RA_XN 28
`define MRP_RA_SRD_HI 15
`define MRP_RA_SRD_LO 8
`define MRP_RA_SIZE_HI 5
`define MRP_RA_SIZE_LO 1
`define MRP_RA_EN 0
// Writable bits: 28, 26..24, 21..16, 15..8, 5..0
`define MRP_RA_RW_MASK 32'h173FFF3F

// Size decoding
`define MRP_N_OFFSET 6'h01
`define MRP_SUB_SHIFT 6'h03
`define MRP_SUB_MIN_N 6'h08

// Reset values and fill patterns
`define MRP_RST_BASE 27'h0000000
`define MRP_RST_ATTR 32'h00000000
`define MRP_RST_RNUM 4'h0
`define MRP_RST_DATA 32'h00000000
`define MRP_ONES 32'hFFFFFFFF
`define MRP_ZERO 32'h00000000

`endif

// file: core/mrp_region.v
// One protection region: descriptor storage and address match
`timescale 1ns/10ps
`include "mrp_defines.vh"
module mrp_region #(
   parameter [3:0] REGION_ID = 4'h0
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Committed write from the bus slave
   input wire wr_base,
   input wire wr_attr,
   input wire [3:0] wr_be,
   input wire [3:0] wr_target,
   input wire [31:0] wdata,
   // Address under check
   input wire [31:0] chk_addr,
   // Read back and match results
   output wire [31:0] base_rd,
   output wire [31:0] attr_rd,
   output wire hit,
   output wire no_execute
);

   reg [31:`MRP_RB_ADDR_LO] base_reg;
   reg [31:0] attr_reg;
   wire mine;
   wire [31:0] lane;
   wire [31:0] base_full;
   wire [31:0] base_new;
   wire [4:0] size;
   wire [5:0] n_bits;
   wire [31:0] amask;
   wire [31:0] base_eff;
   wire [7:0] subregion_disable_mask;
   wire [5:0] sub_sh;
   wire [31:0] sub_pos;
   wire in_region;
   wire sub_ok;

   // Byte-lane merge of a write into stored bits
   function [31:0] merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [31:0] msk;
      begin
         merge = (old_val & ~msk) | (new_val & msk);
      end
   endfunction

   // Write decode
   assign mine = (wr_target == REGION_ID);
   assign lane = {{8{wr_be[3]}}, {8{wr_be[2]}}, {8{wr_be[1]}}, {8{wr_be[0]}}};
   assign base_full = {base_reg, {`MRP_RB_ADDR_LO{1'b0}}};
   assign base_new = merge(base_full, wdata, lane);

   // Descriptor storage; halves are written independently
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         base_reg <= `MRP_RST_BASE;
         attr_reg <= `MRP_RST_ATTR;
      end else begin
         if (wr_base && mine) begin
            base_reg <= base_new[31:`MRP_RB_ADDR_LO];
         end
         if (wr_attr && mine) begin
            // Every defined field kept exactly as written
            attr_reg <= merge(attr_reg, wdata, lane & `MRP_RA_RW_MASK);
         end
      end
   end

   // Size to address mask: span is two to the power size plus one
   assign size = attr_reg[`MRP_RA_SIZE_HI:`MRP_RA_SIZE_LO];
   assign n_bits = {1'b0, size} + `MRP_N_OFFSET;
   // Shift of 32 empties the mask, so a 4 GB region ignores base
   assign amask = `MRP_ONES << n_bits;
   assign base_eff = base_full & amask;
   assign in_region = ((chk_addr & amask) == base_eff);

   // Subregion pick: top three bits below N; small regions have none
   assign subregion_disable_mask = attr_reg[`MRP_RA_SRD_HI:`MRP_RA_SRD_LO];
   assign sub_sh = n_bits - `MRP_SUB_SHIFT;
   assign sub_pos = chk_addr >> sub_sh;
   assign sub_ok = (n_bits < `MRP_SUB_MIN_N) | ~subregion_disable_mask[sub_pos[2:0]];

   // Match and read back
   assign hit = attr_reg[`MRP_RA_EN] & in_region & sub_ok;
   assign no_execute = attr_reg[`MRP_RA_XN];
   assign base_rd = base_eff;
   assign attr_rd = attr_reg;

endmodule // mrp_region

// file: core/mrp_alias_top.v
// Region programming alias pair with AHB-Lite slave and fetch check
//
// Operation
// - Each subregion mask bit disables its subregion when 1, enables when 0; regions below 256 bytes ignore the mask.
// - Region span is two to the power of size field plus one.
// - All-ones size covers whole map from zero, base ignored.
// - Base address occupies bits 31 down to log2 of region size.
// - Base write with valid 0 updates base of the selected region.
// - Base write with valid 1 reselects region first, then updates it.
// - Valid bit of the base register always reads zero.
// - Region field of base register reads the current selector.
// - Base register: valid at bit 4, region number at bits 3..0.
// - No-execute set blocks instruction fetches where the region is the highest-numbered enabled match.
// - Attribute register accepts word and halfword writes independently.
// - Upper half holds no-execute, permission, type extension, S, C, B.
// - Lower half holds subregion mask, size field and region enable.
// - Attribute writes go to the selected region; enable activates it.
`timescale 1ns/10ps
`include "mrp_defines.vh"
module mrp_alias_top #(
   // At most 16: the selector and region field are four bits wide
   parameter NUM_REGIONS = 8
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave, address phase
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   // AHB-Lite slave, data phase
   input wire [31:0] hwdata,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // Instruction fetch check
   input wire fetch_req,
   input wire [31:0] fetch_addr,
   output wire fetch_done,
   output wire fetch_hit,
   output wire fetch_blocked,
   output wire [3:0] fetch_region,
   // Region state
   output wire [NUM_REGIONS-1:0] region_active
);

   // Bus slave states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WDATA = 3'b010;
   localparam [2:0] ST_RWAIT = 3'b100;
   // Region count cut to the selector compare width on purpose
   localparam [31:0] NUM_WIDE = NUM_REGIONS;
   localparam [4:0] NUM_LIMIT = NUM_WIDE[4:0];

   // Bus slave registers
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg hreadyout_reg;
   reg hreadyout_next;
   reg hresp_reg;
   reg [31:0] hrdata_reg;
   reg ph_base_reg;
   reg ph_attr_reg;
   reg ph_rnum_reg;
   reg [3:0] ph_be_reg;

   // Region number selector
   reg [3:0] rnum_reg;
   reg [3:0] rnum_next;

   // Fetch check registers
   reg fetch_done_reg;
   reg fetch_hit_reg;
   reg fetch_blocked_reg;
   reg [3:0] fetch_region_reg;
   reg [NUM_REGIONS-1:0] region_active_reg;

   // Combinational helpers
   reg [31:0] rd_value;
   reg [3:0] win;
   reg win_any;
   reg win_xn;
   // Separate loop indices so no variable is shared between processes
   integer i;
   integer j;

   wire take;
   wire commit;
   wire wvalid;
   wire wr_base;
   wire wr_attr;
   wire [3:0] wr_target;
   wire [3:0] aph_be;
   wire sel_ok;
   wire [3:0] sel_idx;
   wire [31:0] sel_base;
   wire [31:0] sel_attr;
   wire [32*NUM_REGIONS-1:0] base_bus;
   wire [32*NUM_REGIONS-1:0] attr_bus;
   wire [NUM_REGIONS-1:0] hit_vec;
   wire [NUM_REGIONS-1:0] xn_vec;

   // Byte lanes of a transfer from size and low address bits
   function [3:0] lanes;
      input [2:0] sz;
      input [1:0] a;
      begin
         case (sz)
            `MRP_HSIZE_BYTE: lanes = `MRP_LANES_ONE << a;
            `MRP_HSIZE_HALF: lanes = a[1] ? `MRP_LANES_HI : `MRP_LANES_LO;
            `MRP_HSIZE_WORD: lanes = `MRP_LANES_ALL;
            default: lanes = `MRP_LANES_NONE;
         endcase
      end
   endfunction

   // Word match of an address against a register offset
   function word_is;
      input [31:0] a;
      input [`MRP_OFS_W-1:0] ofs;
      begin
         word_is = (a[`MRP_OFS_W-1:2] == ofs[`MRP_OFS_W-1:2]);
      end
   endfunction

   // Register map inside the 4 KB window, one word each:
   //   base word: address bits above N, valid bit, region field
   //   attribute word: upper half attributes, lower half size, enable
   //   selector word: region number in the low four bits
   // Unused words read zero and drop writes; the window repeats
   // because only the low address bits are decoded

   // Address phase is taken only while the bus is ready
   assign take = hsel & htrans[`MRP_HTRANS_ACT] & hready;
   assign aph_be = lanes(hsize, haddr[1:0]);
   assign commit = (state_reg == ST_WDATA);

   // Slave sequencing: writes need no wait, reads insert one wait so
   // that a read right behind a write sees the committed value
   always @* begin
      state_next = state_reg;
      hreadyout_next = hreadyout_reg;
      case (state_reg)
         ST_IDLE, ST_WDATA: begin
            if (take && hwrite) begin
               state_next = ST_WDATA;
               hreadyout_next = 1'b1;
            end else if (take) begin
               state_next = ST_RWAIT;
               hreadyout_next = 1'b0;
            end else begin
               state_next = ST_IDLE;
               hreadyout_next = 1'b1;
            end
         end
         ST_RWAIT: begin
            state_next = ST_IDLE;
            hreadyout_next = 1'b1;
         end
         default: begin
            state_next = ST_IDLE;
            hreadyout_next = 1'b1;
         end
      endcase
   end

   // Slave state and captured address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
         hreadyout_reg <= 1'b1;
         hresp_reg <= `MRP_RESP_OKAY;
         ph_base_reg <= 1'b0;
         ph_attr_reg <= 1'b0;
         ph_rnum_reg <= 1'b0;
         ph_be_reg <= `MRP_LANES_NONE;
      end else begin
         state_reg <= state_next;
         hreadyout_reg <= hreadyout_next;
         hresp_reg <= `MRP_RESP_OKAY;
         if (take) begin
            // Unmapped words decode to nothing: write dropped, read zero
            ph_base_reg <= word_is(haddr, `MRP_OFS_BASE);
            ph_attr_reg <= word_is(haddr, `MRP_OFS_ATTR);
            ph_rnum_reg <= word_is(haddr, `MRP_OFS_RNUM);
            ph_be_reg <= aph_be;
         end else if (state_reg != ST_RWAIT) begin
            ph_base_reg <= 1'b0;
            ph_attr_reg <= 1'b0;
            ph_rnum_reg <= 1'b0;
            ph_be_reg <= `MRP_LANES_NONE;
         end
      end
   end

   // A valid base write reselects from the written region field,
   // otherwise the write lands in the current selection
   assign wvalid = commit & ph_base_reg & ph_be_reg[0] &
                   hwdata[`MRP_RB_VALID];
   assign wr_target = wvalid ?
                      hwdata[`MRP_RB_REG_HI:`MRP_RB_REG_LO] :
                      rnum_reg;
   assign wr_base = commit & ph_base_reg;
   assign wr_attr = commit & ph_attr_reg;

   // Selector next value; the selector word takes only byte lane 0,
   // the same lane that carries the region field in the base word
   always @* begin
      rnum_next = rnum_reg;
      if (wvalid) begin
         rnum_next = hwdata[`MRP_RB_REG_HI:`MRP_RB_REG_LO];
      end else if (commit && ph_rnum_reg && ph_be_reg[0]) begin
         rnum_next = hwdata[`MRP_RB_REG_HI:`MRP_RB_REG_LO];
      end
   end

   // Selector register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rnum_reg <= `MRP_RST_RNUM;
      end else begin
         rnum_reg <= rnum_next;
      end
   end

   // Region descriptors
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGIONS; gi = gi + 1) begin : g_region
         // Region number cut to the four-bit field on purpose
         localparam [31:0] GID_WIDE = gi;
         localparam [3:0] GID = GID_WIDE[3:0];
         mrp_region #(
            .REGION_ID(GID)
         ) u_region (
            .hclk(hclk),
            .hresetn(hresetn),
            .wr_base(wr_base),
            .wr_attr(wr_attr),
            .wr_be(ph_be_reg),
            .wr_target(wr_target),
            .wdata(hwdata),
            .chk_addr(fetch_addr),
            .base_rd(base_bus[gi*32 +: 32]),
            .attr_rd(attr_bus[gi*32 +: 32]),
            .hit(hit_vec[gi]),
            .no_execute(xn_vec[gi])
         );
      end
   endgenerate

   // Selected region; a selector beyond the implemented set reads zero
   assign sel_ok = ({1'b0, rnum_reg} < NUM_LIMIT);
   assign sel_idx = sel_ok ? rnum_reg : `MRP_RST_RNUM;
   assign sel_base = sel_ok ? base_bus[sel_idx*32 +: 32] : `MRP_ZERO;
   assign sel_attr = sel_ok ? attr_bus[sel_idx*32 +: 32] : `MRP_ZERO;

   // Read mux; base reads follow the current size, so stray low
   // bits of a misaligned base never show
   always @* begin
      rd_value = `MRP_ZERO;
      if (ph_base_reg) begin
         rd_value[31:`MRP_RB_ADDR_LO] = sel_base[31:`MRP_RB_ADDR_LO];
         rd_value[`MRP_RB_VALID] = 1'b0;
         rd_value[`MRP_RB_REG_HI:`MRP_RB_REG_LO] = rnum_reg;
      end else if (ph_attr_reg) begin
         rd_value = sel_attr;
      end else if (ph_rnum_reg) begin
         rd_value[`MRP_RB_REG_HI:`MRP_RB_REG_LO] = rnum_reg;
      end
   end

   // Read data is registered in the wait cycle and held afterwards
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= `MRP_RST_DATA;
      end else if (state_reg == ST_RWAIT) begin
         hrdata_reg <= rd_value;
      end
   end

   // Highest numbered matching region wins, so a later region can
   // carve an exception out of a larger one below it
   always @* begin
      win = `MRP_RST_RNUM;
      win_any = 1'b0;
      win_xn = 1'b0;
      for (i = 0; i < NUM_REGIONS; i = i + 1) begin
         if (hit_vec[i]) begin
            win = i[3:0];
            win_any = 1'b1;
            win_xn = xn_vec[i];
         end
      end
   end

   // Fetch verdict one cycle after the request; addresses outside
   // every enabled region are left to the default map, so not blocked
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fetch_done_reg <= 1'b0;
         fetch_hit_reg <= 1'b0;
         fetch_blocked_reg <= 1'b0;
         fetch_region_reg <= `MRP_RST_RNUM;
      end else begin
         fetch_done_reg <= fetch_req;
         if (fetch_req) begin
            fetch_hit_reg <= win_any;
            fetch_blocked_reg <= win_any & win_xn;
            fetch_region_reg <= win;
         end
      end
   end

   // Enabled regions shown to the rest of the unit
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         region_active_reg <= {NUM_REGIONS{1'b0}};
      end else begin
         for (j = 0; j < NUM_REGIONS; j = j + 1) begin
            region_active_reg[j] <= attr_bus[j*32 + `MRP_RA_EN];
         end
      end
   end

   // Output drive
   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign fetch_done = fetch_done_reg;
   assign fetch_hit = fetch_hit_reg;
   assign fetch_blocked = fetch_blocked_reg;
   assign fetch_region = fetch_region_reg;
   assign region_active = region_active_reg;

endmodule // mrp_alias_top

// file: tb/mrp_master.sv
// AHB-Lite master model standing in for the programming software
`timescale 1ns/10ps
module mrp_master (
   // Clock and bus answer
   input wire hclk,
   input wire hready,
   input wire [31:0] hrdata,
   // Bus request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // One single transfer; call just after a rising edge
   task xfer(input [31:0] a, input [31:0] wd, input wr, input [2:0] s,
      output [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= s;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      // Released lines show a changing value, not the old one
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= wd;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      rd = hrdata;
      hwdata <= ~wd;
   endtask
endmodule // mrp_master

// file: tb/mrp_alias_top_chk.sv
// Port-level assertions for the region programming alias block
`timescale 1ns/10ps
module mrp_chk (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // Fetch check
   input wire fetch_req,
   input wire fetch_done,
   input wire fetch_hit,
   input wire fetch_blocked,
   input wire [3:0] fetch_region
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Transfer accepted at this edge
   wire take = hsel & htrans[1] & hready;
   wire rd_take = take & ~hwrite;

   AST_RESP_OKAY: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   AST_RD_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait not one cycle");
   AST_VALID_ZERO: assert property (rd_take && haddr[11:2] == 10'h000
      |-> ##2 !hrdata[4]) else $error("valid bit read as one");
   AST_ATTR_RSVD: assert property (rd_take && haddr[11:2] == 10'h001
      |-> ##2 (hrdata & ~32'h173FFF3F) == 32'h0)
      else $error("reserved attribute bit set");
   AST_DONE: assert property (fetch_req |=> fetch_done)
      else $error("fetch check not answered");
   AST_NO_DONE: assert property (!fetch_req |=> !fetch_done)
      else $error("spurious fetch answer");
   AST_BLK_HIT: assert property (fetch_blocked |-> fetch_hit)
      else $error("blocked without a hit");
   AST_HOLD: assert property (!fetch_req |=>
      $stable({fetch_hit, fetch_blocked, fetch_region}))
      else $error("verdict changed without request");
endmodule // mrp_chk

bind mrp_alias_top mrp_chk i_mrp_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .fetch_req,
   .fetch_done, .fetch_hit, .fetch_blocked, .fetch_region);

// file: tb/tb_mrp_alias_top.sv
// Self-checking testbench for the region programming alias block
`timescale 1ns/10ps
module tb_mrp_alias_top;
   logic hclk, hresetn, fetch_req;
   logic [31:0] fetch_addr, d;
   wire hsel, hwrite, hready, hresp, fetch_done, fetch_hit, fetch_blocked;
   wire [31:0] haddr, hwdata, hrdata;
   wire [1:0] htrans;
   wire [2:0] hsize;
   wire [3:0] fetch_region;
   wire [7:0] act;
   int fail_count, n_tests;

   mrp_alias_top i_mrp_alias_top (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .fetch_done(fetch_done),
      .fetch_hit(fetch_hit), .fetch_blocked(fetch_blocked),
      .fetch_region(fetch_region), .region_active(act));
   mrp_master i_mrp_master (.hclk(hclk), .hready(hready), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));

   // Compare and count
   task chk(input [31:0] got, input [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("Checks %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Bus helpers; hs is a halfword store
   task wr(input [31:0] a, input [31:0] v);
      i_mrp_master.xfer(a, v, 1'b1, 3'h2, d);
   endtask
   task hs(input [31:0] a, input [31:0] v);
      i_mrp_master.xfer(a, v, 1'b1, 3'h1, d);
   endtask
   task rdc(input [31:0] a, input [31:0] exp);
      i_mrp_master.xfer(a, 32'h0, 1'b0, 3'h2, d);
      chk(d, exp);
   endtask
   // One fetch check: verdict bits are done, hit, blocked
   task fchk(input [31:0] a, input [2:0] exp);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      @(posedge hclk);
      fetch_req <= 1'b0;
      fetch_addr <= ~a;
      #1;
      chk({29'h0, fetch_done, fetch_hit, fetch_blocked},
         {29'h0, exp});
      if (exp[1]) chk({28'h0, fetch_region}, 32'h3);
      @(posedge hclk);
   endtask

   // Reset values and an unmapped word
   task t_reset;
      rdc(32'h0, 32'h0);
      rdc(32'h4, 32'h0);
      rdc(32'hC, 32'h0);
      chk({24'h0, act}, 32'h0);
   endtask
   // Selector load through the base register
   task t_select;
      wr(32'h0, 32'h20000013);
      rdc(32'h0, 32'h20000003);
      wr(32'h0, 32'h40000405);
      rdc(32'h8, 32'h3);
      rdc(32'h0, 32'h40000403);
   endtask
   // Attribute fields, halfword lanes and enable
   task t_attr;
      wr(32'h4, 32'hFFFFFFFF);
      rdc(32'h4, 32'h173FFF3F);
      chk({24'h0, act}, 32'h08);
      rdc(32'h0, 32'h3);
      hs(32'h6, 32'h0);
      rdc(32'h4, 32'h0000FF3F);
      hs(32'h4, 32'h00000A12);
      rdc(32'h4, 32'h00000A12);
      chk({24'h0, act}, 32'h0);
      rdc(32'h0, 32'h40000403);
   endtask
   // Fetch checks: span, subregions, no-execute, whole map
   task t_fetch;
      wr(32'h4, 32'h10000413);
      fchk(32'h40000400, 3'b111);
      fchk(32'h400007FF, 3'b111);
      fchk(32'h40000500, 3'b100);
      fchk(32'h40000800, 3'b100);
      fchk(32'h400003FC, 3'b100);
      wr(32'h4, 32'h0000003F);
      fchk(32'h00000010, 3'b110);
   endtask
   // Selector word, byte lanes, unmapped word, unimplemented region
   task t_lanes;
      wr(32'h8, 32'h00000005);
      rdc(32'h8, 32'h5);
      rdc(32'h0, 32'h5);
      i_mrp_master.xfer(32'h1, 32'h0000AB1F, 1'b1, 3'h0, d);
      rdc(32'h0, 32'h0000AB05);
      wr(32'hC, 32'hFFFFFFFF);
      rdc(32'hC, 32'h0);
      wr(32'h0, 32'h80000019);
      rdc(32'h0, 32'h9);
      rdc(32'h4, 32'h0);
      wr(32'h8, 32'h00000001);
      rdc(32'h0, 32'h1);
   endtask

   // Clock at 10 MHz
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Main sequence
   initial begin
      hresetn = 1'b0;
      fetch_req = 1'b0;
      fetch_addr = 32'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_select;
      t_attr;
      t_fetch;
      t_lanes;
      final_report;
   end
   // Hang guard, well past the hundred or so cycles needed
   initial begin
      #200000;
      fail_count++;
      final_report;
   end
endmodule // tb_mrp_alias_top
